// file: design/ddsc_pkg.sv
// package: constants and types of the dual converter serial command port
`default_nettype none
package ddsc_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int CMD_W  = 4;
  localparam int CNT_W  = 5;
  localparam int NCH    = 2;

  // bit counter marks
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

  // command codes carried in the top four bits of a word
  localparam logic [CMD_W-1:0] CMD_NOP      = 4'h0;
  localparam logic [CMD_W-1:0] CMD_LDUP_A   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_RB_A     = 4'h2;
  localparam logic [CMD_W-1:0] CMD_LDIN_A   = 4'h3;
  localparam logic [CMD_W-1:0] CMD_LDUP_B   = 4'h4;
  localparam logic [CMD_W-1:0] CMD_RB_B     = 4'h5;
  localparam logic [CMD_W-1:0] CMD_LDIN_B   = 4'h6;
  localparam logic [CMD_W-1:0] CMD_UPD_AB   = 4'h7;
  localparam logic [CMD_W-1:0] CMD_LDIN_AB  = 4'h8;
  localparam logic [CMD_W-1:0] CMD_CHAIN_OFF = 4'h9;
  localparam logic [CMD_W-1:0] CMD_RISE_EDGE = 4'hA;
  localparam logic [CMD_W-1:0] CMD_CLR_ZERO = 4'hB;
  localparam logic [CMD_W-1:0] CMD_CLR_MID  = 4'hC;
  localparam logic [CMD_W-1:0] CMD_CTRL     = 4'hD;

  // control word field positions inside the 12-bit data field
  localparam int CTL_DRV_HI_POS = 11;
  localparam int CTL_DRV_LO_POS = 10;
  localparam int CTL_CHAIN_POS  = 9;
  localparam int CTL_HCLR_POS   = 8;
  localparam int CTL_EDGE_POS   = 7;

  // serial output driver modes
  localparam logic [1:0] DRV_FULL = 2'h0;
  localparam logic [1:0] DRV_WEAK = 2'h1;
  localparam logic [1:0] DRV_OD   = 2'h2;
  localparam logic [1:0] DRV_OFF  = 2'h3;

  localparam logic [DATA_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] CODE_MID  = 12'h800;
  localparam logic [CMD_W-1:0]  RB_PAD    = 4'h0;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdin;
  } ddsc_link_type;

  typedef struct packed {
    logic [1:0] drive;
    logic       chain;
    logic       hclr;
    logic       rise_edge;
  } ddsc_cfg_type;

  localparam ddsc_cfg_type CFG_RST = '{drive: DRV_FULL, chain: 1'b1, hclr: 1'b0,
                                       rise_edge: 1'b0};

  typedef struct packed {
    logic [NCH-1:0]    load_in;
    logic [NCH-1:0]    update;
    logic              clr_zero;
    logic              clr_mid;
    logic [DATA_W-1:0] data;
  } ddsc_dac_ctl_type;

  typedef enum logic [1:0] {ST_SLEEP, ST_SHIFT, ST_HALT} ddsc_state_type;
endpackage
`default_nettype wire

// file: design/ddsc_sync.sv
// two-flop synchroniser for the three link pins
`default_nettype none
module ddsc_sync (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire ddsc_pkg::ddsc_link_type pin_in,
  output var  ddsc_pkg::ddsc_link_type pin_s
);
  import ddsc_pkg::*;

  logic [2:0] meta_r;
  logic [2:0] stab_r;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        // serial clock rests low, the other pins rest high: no false edge after reset
        if (srst) begin
          meta_r[gi] <= (gi != 2);
          stab_r[gi] <= (gi != 2);
        end else begin
          meta_r[gi] <= pin_in[gi];
          stab_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign pin_s = stab_r;
endmodule
`default_nettype wire

// file: design/ddsc_dac_regs.sv
// input and converter registers of both channels
`default_nettype none
module ddsc_dac_regs (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire ddsc_pkg::ddsc_dac_ctl_type  ctl,
  output var  logic [ddsc_pkg::NCH-1:0][ddsc_pkg::DATA_W-1:0] dac_code
);
  import ddsc_pkg::*;

  logic [NCH-1:0][DATA_W-1:0] in_r;
  logic [NCH-1:0][DATA_W-1:0] dac_r;

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          in_r[gc]  <= CODE_ZERO;
          dac_r[gc] <= CODE_ZERO;
        end else if (ctl.clr_zero) begin
          in_r[gc]  <= CODE_ZERO;
          dac_r[gc] <= CODE_ZERO;
        end else if (ctl.clr_mid) begin
          in_r[gc]  <= CODE_MID;
          dac_r[gc] <= CODE_MID;
        end else begin
          if (ctl.load_in[gc]) begin
            in_r[gc] <= ctl.data;
          end
          // load-and-update takes the new data, not the stale input register
          if (ctl.update[gc]) begin
            dac_r[gc] <= ctl.load_in[gc] ? ctl.data : in_r[gc];
          end
        end
      end
    end
  endgenerate

  assign dac_code = dac_r;
endmodule
`default_nettype wire

// file: design/ddsc_port.sv
// serial command port of a dual 12-bit current-output converter
// Summary of operation
// - each word is sixteen bits: four command bits then twelve data bits
// - receiver wakes when frame select falls, otherwise stays asleep
// - frame select rising puts clock and data receivers to sleep
// - after reset bits are sampled on the falling serial clock edge
// - after reset chained pass-through is on, shifted bits reach serial out
// - both converter registers hold zero code after reset
// - command 1101 writes the control word from the data field
// - drive field 00 full, 01 weak, 10 open drain, 11 off
// - readback command puts the chosen converter code on serial out
// - commands clear both outputs to zero code or mid-scale code
// - a command switches sampling to the rising serial clock edge
// - a command turns chained pass-through off
// - chained mode: bits past sixteen clocks pass out on serial out
// - standalone: word executes on sixteenth edge, then waits for new frame
// - standalone: frame select rising mid-word discards the word
// - chained mode: word executes when frame select rises
`default_nettype none
module ddsc_port (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire ddsc_pkg::ddsc_link_type link_pins,
  output var  logic                   serial_data_out,
  output var  logic                   serial_data_out_oe,
  output var  logic                   serial_out_weak,
  output var  logic                   rx_awake,
  output var  logic                   word_done,
  output var  ddsc_pkg::ddsc_cfg_type  cfg_out,
  output var  logic [11:0]            current_output_a_code,
  output var  logic [11:0]            current_output_b_code
);
  import ddsc_pkg::*;

  ddsc_link_type              pin_s;
  logic                       sclk_d_r;
  logic                       sync_d_r;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       sync_fall;
  logic                       sync_rise;
  logic                       sample_edge;
  logic                       launch_edge;
  ddsc_state_type             state_r;
  logic [CNT_W-1:0]           cnt_r;
  logic [WORD_W-1:0]          shift_r;
  logic                       shift_en;
  logic                       sa_done;
  logic                       ch_done;
  logic                       exec;
  logic [WORD_W-1:0]          word;
  logic [CMD_W-1:0]           cmd;
  logic [DATA_W-1:0]          data;
  logic                       rb_hit;
  logic [DATA_W-1:0]          rb_code;
  ddsc_cfg_type               cfg_r;
  logic                       rb_act_r;
  logic                       tx_bit_r;
  logic                       tx_nxt;
  logic                       drive_en;
  ddsc_dac_ctl_type           dac_ctl;
  logic [NCH-1:0][DATA_W-1:0] dac_code;
  logic                       tx_r;
  logic                       tx_oe_r;
  logic                       weak_r;
  logic                       awake_r;
  logic                       done_r;

  ddsc_sync u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .pin_in  (link_pins),
    .pin_s   (pin_s)
  );

  ddsc_dac_regs u_dac (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .ctl      (dac_ctl),
    .dac_code (dac_code)
  );

  // edge finding on the synchronised pins; the link clock is slow enough
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
      sync_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pin_s.sclk;
      sync_d_r <= pin_s.sync_n;
    end
  end

  assign sclk_rise   = pin_s.sclk & ~sclk_d_r;
  assign sclk_fall   = ~pin_s.sclk & sclk_d_r;
  assign sync_fall   = ~pin_s.sync_n & sync_d_r;
  assign sync_rise   = pin_s.sync_n & ~sync_d_r;
  assign sample_edge = cfg_r.rise_edge ? sclk_rise : sclk_fall;
  assign launch_edge = cfg_r.rise_edge ? sclk_fall : sclk_rise;

  // frame state: asleep, shifting, or halted after a standalone word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_SLEEP;
    end else if (sync_fall) begin
      state_r <= ST_SHIFT;
    end else begin
      case (state_r)
        ST_SHIFT: begin
          if (sync_rise) begin
            state_r <= ST_SLEEP;
          end else if (sa_done) begin
            state_r <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (sync_rise) begin
            state_r <= ST_SLEEP;
          end
        end
        default: state_r <= ST_SLEEP;
      endcase
    end
  end

  // sleeping receivers ignore the clock and data pins entirely
  assign shift_en = (state_r == ST_SHIFT) && sample_edge && ~pin_s.sync_n;
  assign sa_done  = shift_en && ~cfg_r.chain && (cnt_r == CNT_LAST);
  assign ch_done  = sync_rise && (state_r == ST_SHIFT) && cfg_r.chain
                    && (cnt_r == CNT_FULL);
  // a partial standalone word never reaches exec: it is simply dropped
  assign exec     = sa_done | ch_done;
  assign word     = sa_done ? {shift_r[WORD_W-2:0], pin_s.sdin} : shift_r;
  assign cmd      = word[WORD_W-1:DATA_W];
  assign data     = word[DATA_W-1:0];
  assign rb_hit   = exec && ((cmd == CMD_RB_A) || (cmd == CMD_RB_B));
  assign rb_code  = (cmd == CMD_RB_B) ? dac_code[1] : dac_code[0];

  // bit counter, restarted by each frame select fall
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= CNT_ZERO;
    end else if (sync_fall) begin
      cnt_r <= CNT_ZERO;
    end else if (shift_en && (cnt_r != CNT_FULL)) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // shift register: msb leaves first, so chained bits ripple onward
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_r <= '0;
    end else if (rb_hit) begin
      shift_r <= {RB_PAD, rb_code};
    end else if (shift_en) begin
      shift_r <= {shift_r[WORD_W-2:0], pin_s.sdin};
    end
  end

  // configuration written by commands
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_r <= CFG_RST;
    end else if (exec) begin
      case (cmd)
        CMD_CHAIN_OFF: cfg_r.chain <= 1'b0;
        CMD_RISE_EDGE: cfg_r.rise_edge <= 1'b1;
        CMD_CTRL: begin
          cfg_r.drive     <= {data[CTL_DRV_HI_POS], data[CTL_DRV_LO_POS]};
          cfg_r.chain     <= data[CTL_CHAIN_POS];
          cfg_r.hclr      <= data[CTL_HCLR_POS];
          cfg_r.rise_edge <= data[CTL_EDGE_POS];
        end
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // converter register controls
  always_comb begin
    dac_ctl          = '0;
    dac_ctl.data     = data;
    if (exec) begin
      case (cmd)
        CMD_LDUP_A: begin
          dac_ctl.load_in = 2'h1;
          dac_ctl.update  = 2'h1;
        end
        CMD_LDIN_A:   dac_ctl.load_in = 2'h1;
        CMD_LDUP_B: begin
          dac_ctl.load_in = 2'h2;
          dac_ctl.update  = 2'h2;
        end
        CMD_LDIN_B:   dac_ctl.load_in = 2'h2;
        CMD_UPD_AB:   dac_ctl.update = 2'h3;
        CMD_LDIN_AB:  dac_ctl.load_in = 2'h3;
        CMD_CLR_ZERO: dac_ctl.clr_zero = 1'b1;
        CMD_CLR_MID:  dac_ctl.clr_mid = 1'b1;
        default:      dac_ctl.update = 2'h0;
      endcase
    end
  end

  // standalone readback holds the driver on until the next word completes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rb_act_r <= 1'b0;
    end else if (rb_hit) begin
      rb_act_r <= 1'b1;
    end else if (sa_done) begin
      rb_act_r <= 1'b0;
    end
  end

  // outgoing bit changes on the edge opposite the sampling edge
  always_comb begin
    tx_nxt = tx_bit_r;
    if (rb_hit) begin
      tx_nxt = RB_PAD[CMD_W-1];
    end else if (launch_edge && (state_r != ST_SLEEP)) begin
      tx_nxt = shift_r[WORD_W-1];
    end
  end

  assign drive_en = cfg_r.chain | rb_act_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_bit_r <= 1'b0;
    end else begin
      tx_bit_r <= tx_nxt;
    end
  end

  // pin driver; enable follows the next bit so open drain never glitches high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_r    <= 1'b0;
      tx_oe_r <= 1'b0;
      weak_r  <= 1'b0;
    end else begin
      weak_r <= (cfg_r.drive == DRV_WEAK);
      case (cfg_r.drive)
        DRV_OD: begin
          tx_r    <= 1'b0;
          tx_oe_r <= drive_en & ~tx_nxt;
        end
        DRV_OFF: begin
          tx_r    <= 1'b0;
          tx_oe_r <= 1'b0;
        end
        default: begin
          tx_r    <= tx_nxt;
          tx_oe_r <= drive_en;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awake_r <= 1'b0;
    end else if (sync_fall) begin
      awake_r <= 1'b1;
    end else if (sync_rise) begin
      awake_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= exec;
    end
  end

  assign serial_data_out       = tx_r;
  assign serial_data_out_oe    = tx_oe_r;
  assign serial_out_weak       = weak_r;
  assign rx_awake              = awake_r;
  assign word_done             = done_r;
  assign cfg_out               = cfg_r;
  assign current_output_a_code = dac_code[0];
  assign current_output_b_code = dac_code[1];

  // checks
  property p_wake;
    @(posedge sys_clk) disable iff (srst) sync_fall |=> awake_r && state_r == ST_SHIFT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on frame start");

  property p_sleep;
    @(posedge sys_clk) disable iff (srst) sync_rise |=> !awake_r && state_r == ST_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep on frame end");

  property p_reset_cfg;
    @(posedge sys_clk) srst |=> !cfg_r.rise_edge && cfg_r.chain;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");

  property p_reset_codes;
    @(posedge sys_clk) srst |=> dac_code[0] == CODE_ZERO && dac_code[1] == CODE_ZERO;
  endproperty
  a_reset_codes: assert property (p_reset_codes) else $error("codes not zero");

  property p_ctrl;
    @(posedge sys_clk) disable iff (srst)
      exec && cmd == CMD_CTRL |=> cfg_r.chain == $past(data[CTL_CHAIN_POS])
      && cfg_r.drive == $past(data[CTL_DRV_HI_POS:CTL_DRV_LO_POS]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control word not applied");

  property p_drv_off;
    @(posedge sys_clk) disable iff (srst) (cfg_r.drive == DRV_OFF) [*2] |-> !tx_oe_r;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("disabled driver drives");

  property p_readback;
    @(posedge sys_clk) disable iff (srst)
      exec && cmd == CMD_RB_B |=> shift_r == {RB_PAD, dac_code[1]} && rb_act_r;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not loaded");

  property p_clr_mid;
    @(posedge sys_clk) disable iff (srst)
      exec && cmd == CMD_CLR_MID |=> dac_code[0] == CODE_MID && dac_code[1] == CODE_MID;
  endproperty
  a_clr_mid: assert property (p_clr_mid) else $error("mid-scale clear failed");

  property p_edge_cmd;
    @(posedge sys_clk) disable iff (srst) exec && cmd == CMD_RISE_EDGE |=> cfg_r.rise_edge;
  endproperty
  a_edge_cmd: assert property (p_edge_cmd) else $error("edge not switched");

  property p_chain_off;
    @(posedge sys_clk) disable iff (srst) exec && cmd == CMD_CHAIN_OFF |=> !cfg_r.chain;
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("chain not off");

  property p_msb_first;
    @(posedge sys_clk) disable iff (srst)
      shift_en && !rb_hit |=> shift_r[0] == $past(pin_s.sdin)
      && shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bad shift order");

  property p_sa_halt;
    @(posedge sys_clk) disable iff (srst)
      sa_done ##1 !sync_fall [*2] |-> state_r == ST_HALT && !shift_en;
  endproperty
  a_sa_halt: assert property (p_sa_halt) else $error("extra clocks accepted");

  property p_abort;
    @(posedge sys_clk) disable iff (srst) sync_rise && !cfg_r.chain |-> !exec ##1 !done_r;
  endproperty
  a_abort: assert property (p_abort) else $error("partial word executed");

  property p_chain_exec;
    @(posedge sys_clk) disable iff (srst)
      sync_rise && cfg_r.chain && state_r == ST_SHIFT && cnt_r == CNT_FULL |=> done_r;
  endproperty
  a_chain_exec: assert property (p_chain_exec) else $error("chained word lost");

  c_load_a: cover property (@(posedge sys_clk) exec && cmd == CMD_LDUP_A);
  c_readback: cover property (@(posedge sys_clk) rb_hit ##[1:400] sa_done);
  c_chain: cover property (@(posedge sys_clk) ch_done);
  c_ctrl: cover property (@(posedge sys_clk) exec && cmd == CMD_CTRL);
endmodule
`default_nettype wire

// file: tb/ddsc_host_model.sv
// host serial master model driving the link pins of the command port
`default_nettype none
module ddsc_host_model (
  input  wire logic                    sys_clk,
  input  wire logic                    serial_data_out,
  output var  ddsc_pkg::ddsc_link_type link_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddsc_pkg::*;
  logic [31:0] rd_bits;
  initial link_pins = '{sclk: 1'b0, sync_n: 1'b1, sdin: 1'b1};
  // sclk rests low between frames; 8 sys_clk per bit gives the 800 ns period
  task automatic frame(input logic [31:0] bits, input int nbits);
    int i;
    rd_bits = '0;
    @(posedge sys_clk);
    link_pins.sync_n <= 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      repeat (2) @(posedge sys_clk);
      rd_bits = {rd_bits[30:0], serial_data_out};
      link_pins.sdin <= bits[i];
      repeat (2) @(posedge sys_clk);
      link_pins.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      link_pins.sclk <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    rd_bits = {rd_bits[30:0], serial_data_out};
    repeat (2) @(posedge sys_clk);
    link_pins.sync_n <= 1'b1;
    // released data line shows the inverse so stale bits are never trusted
    link_pins.sdin <= ~bits[0];
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/ddsc_port_bench.sv
// self-checking bench of the serial command port
`default_nettype none
module ddsc_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ddsc_pkg::*;
  typedef struct packed {
    logic [11:0]  a;
    logic [11:0]  b;
    ddsc_cfg_type cfg;
  } ddsc_exp_type;
  logic                   sys_clk;
  logic                   srst;
  ddsc_link_type          link_pins;
  logic                   serial_data_out;
  logic                   serial_data_out_oe;
  logic                   serial_out_weak;
  logic                   rx_awake;
  logic                   word_done;
  ddsc_cfg_type           cfg_out;
  logic [11:0]            code_a;
  logic [11:0]            code_b;
  ddsc_exp_type           exp_q[$];
  ddsc_exp_type           got;
  logic [11:0]            m_a, m_b, m_ia, m_ib;
  ddsc_cfg_type           m_cfg;
  logic [31:0]            rng;
  logic [15:0]            w;
  logic [15:0]            w1;
  int                     fails;
  int                     n_tests;
  int                     cyc;
  int                     k;

  ddsc_port DUT (
    .sys_clk               (sys_clk),
    .srst                  (srst),
    .link_pins             (link_pins),
    .serial_data_out       (serial_data_out),
    .serial_data_out_oe    (serial_data_out_oe),
    .serial_out_weak       (serial_out_weak),
    .rx_awake              (rx_awake),
    .word_done             (word_done),
    .cfg_out               (cfg_out),
    .current_output_a_code (code_a),
    .current_output_b_code (code_b)
  );
  ddsc_host_model host (
    .sys_clk         (sys_clk),
    .serial_data_out (serial_data_out),
    .link_pins       (link_pins)
  );

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  function automatic logic [11:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[11:0];
  endfunction

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // expected state after a word executes
  task automatic note(input logic [15:0] wd);
    logic [11:0] d;
    d = wd[11:0];
    case (wd[15:12])
      CMD_LDUP_A:    begin m_ia = d; m_a = d; end
      CMD_LDIN_A:    m_ia = d;
      CMD_LDUP_B:    begin m_ib = d; m_b = d; end
      CMD_LDIN_B:    m_ib = d;
      CMD_UPD_AB:    begin m_a = m_ia; m_b = m_ib; end
      CMD_LDIN_AB:   begin m_ia = d; m_ib = d; end
      CMD_CHAIN_OFF: m_cfg.chain = 1'b0;
      CMD_RISE_EDGE: m_cfg.rise_edge = 1'b1;
      CMD_CLR_ZERO:  {m_a, m_b, m_ia, m_ib} = {4{CODE_ZERO}};
      CMD_CLR_MID:   {m_a, m_b, m_ia, m_ib} = {4{CODE_MID}};
      CMD_CTRL:      m_cfg = '{drive: d[11:10], chain: d[9], hclr: d[8], rise_edge: d[7]};
      default: ;
    endcase
    exp_q.push_back('{a: m_a, b: m_b, cfg: m_cfg});
  endtask

  task automatic send(input logic [31:0] bits, input int n);
    fork
      host.frame(bits, n);
      begin
        repeat (8) @(posedge sys_clk);
        check(rx_awake === 1'b1, "receiver asleep in frame");
      end
    join
    check(rx_awake === 1'b0, "receiver awake after frame");
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // results are compared whenever a word completes
  always @(negedge sys_clk) begin
    if (word_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "unexpected word completion");
      end else begin
        got = exp_q.pop_front();
        check(code_a === got.a && code_b === got.b && cfg_out === got.cfg, "word result");
      end
    end
  end

  // hang guard, the planned run is well under this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    srst = 1'b1;
    rng = 32'hB8E3;
    {m_a, m_b, m_ia, m_ib} = {4{CODE_ZERO}};
    m_cfg = CFG_RST;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    check(cfg_out === CFG_RST, "reset config");
    check(code_a === CODE_ZERO && code_b === CODE_ZERO, "reset codes");
    check(rx_awake === 1'b0 && word_done === 1'b0, "reset flags");
    $display("test 1 done");
    w = {CMD_LDUP_A, rnd()};
    note(w);
    send({16'h0000, w}, 16);
    w1 = {CMD_LDUP_B, rnd()};
    w = {CMD_LDUP_A, rnd()};
    note(w);
    send({w1, w}, 32);
    check(host.rd_bits[15:0] === w1, "chained pass-through");
    $display("test 2 done");
    for (k = 3; k >= 0; k--) begin
      w = rnd();
      w = {CMD_CTRL, k[1:0], 1'b1, w[8], 1'b0, w[6:0]};
      note(w);
      send({16'h0000, w}, 16);
      check(serial_out_weak === (k == 1), "weak driver select");
      if (k == 3)
        check(serial_data_out_oe === 1'b0, "output disabled");
      if (k == 2)
        check(serial_data_out === 1'b0, "open drain data held low");
      if (k == 0)
        check(serial_data_out_oe === 1'b1, "full driver enabled");
    end
    $display("test 3 done");
    note({CMD_CHAIN_OFF, 12'h000});
    send({16'h0000, CMD_CHAIN_OFF, 12'h000}, 16);
    w = {CMD_LDUP_B, rnd()};
    note(w);
    send({12'h000, w, 4'hA}, 20);
    w = {CMD_LDUP_A, 12'h5A5};
    send({22'h0, w[15:6]}, 10);
    @(negedge sys_clk);
    check(code_a === m_a, "aborted word changed a code");
    note({CMD_RB_B, 12'h000});
    send({16'h0000, CMD_RB_B, 12'h000}, 16);
    note(16'h0000);
    send(32'h0000_0000, 16);
    check(host.rd_bits[15:0] === {RB_PAD, m_b}, "readback data");
    $display("test 4 done");
    w = {CMD_LDIN_AB, rnd()};
    note({CMD_CLR_MID, 12'h000});
    send({16'h0000, CMD_CLR_MID, 12'h000}, 16);
    note(w);
    send({16'h0000, w}, 16);
    note(16'hE3C1);
    send(32'h0000_E3C1, 16);
    note({CMD_UPD_AB, 12'h000});
    send({16'h0000, CMD_UPD_AB, 12'h000}, 16);
    note({CMD_CLR_ZERO, 12'h000});
    send({16'h0000, CMD_CLR_ZERO, 12'h000}, 16);
    $display("test 5 done");
    note({CMD_RISE_EDGE, 12'h000});
    send({16'h0000, CMD_RISE_EDGE, 12'h000}, 16);
    w = {CMD_LDUP_A, rnd()};
    note(w);
    send({16'h0000, w}, 16);
    check(exp_q.size() == 0, "missing word completions");
    $display("test 6 done");
    finish_test();
  end
endmodule
`default_nettype wire
